// ==== nsuo_status_out.sv ====
// link line gating, indicator lamps, remote flag and cycle-start pulse
`timescale 1ns/1ps
// Function
// (R1) drive enable high throughout own transmission
// (R2) line bits paced by engine bit strobe
// (R3) receive line ignored while driving
// (R4) all four lamps light on low
// (R5) monitor and commander lamps: normal operation
// (R6) link but no commander: distinct lamps
// (R7) address clash: only severe lamp lit
// (R8) new no-link destination flashes mild lamp
// (R9) three-scan no-link flashes severe lamp
// (R10) disconnection or reset flashes both lamps
// (R11) fault blinks lamps, period names fault
// (R12) addressed flag instruction drives flag low
// (R13) packet without our flag releases flag
// (R14) flag accepted from any station
// (R15) cycle start: low pulse two bits
// (R16) flashes, blinks and pulse from counters
module nsuo_status_out #(
  parameter int unsigned FLASH_CYCLES = nsuo_pkg::FLASH_CYC,
  parameter int unsigned BLINK1_CYC   = nsuo_pkg::BLINK_SW_CYC,
  parameter int unsigned BLINK2_CYC   = nsuo_pkg::BLINK_ROM_CYC,
  parameter int unsigned BLINK3_CYC   = nsuo_pkg::BLINK_MEM_CYC
) (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          bit_strobe,
  input  wire logic          tx_active,
  input  wire logic          tx_bit,
  output logic               ser_tx_data,
  output logic               ser_tx_drive_en,
  input  wire logic          ser_rx_data,
  output logic               rx_bit,
  input  wire nsuo_pkg::nsuo_addr_t own_station_addr,
  input  wire nsuo_pkg::nsuo_addr_t own_station_span,
  input  wire nsuo_pkg::nsuo_addr_t commander_station_addr,
  input  wire logic          link_any,
  input  wire logic          commander_linked,
  input  wire logic          no_link_new,
  input  wire logic          no_link3_new,
  input  wire logic          disconnect3,
  input  wire logic          fault_switch_read,
  input  wire logic          fault_flash_rom,
  input  wire logic          fault_memory,
  input  wire logic          rx_pkt_done,
  input  wire logic          rx_flag_for_us,
  input  wire logic          cycle_start,
  output logic               link_monitor_led_n,
  output logic               mild_warn_led_n,
  output logic               severe_warn_led_n,
  output logic               commander_present_led,
  output logic               remote_flag_n,
  output logic               cycle_start_pulse_n
);
  import nsuo_pkg::*;

  // ----------------------------------------------------------------
  // reset release and pin input synchroniser
  // ----------------------------------------------------------------
  logic rst_s1_q, rst_n;
  logic rx_s1_q, rx_s2_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_s1_q <= LINE_IDLE;
      rx_s2_q <= LINE_IDLE;
    end else begin
      rx_s1_q <= ser_rx_data;
      rx_s2_q <= rx_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // serial line
  // ----------------------------------------------------------------
  // engine changes tx_bit once per bit strobe; registering here keeps
  // data and enable aligned on the same edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ser_tx_data     <= LINE_IDLE;
      ser_tx_drive_en <= 1'b0;
    end else begin
      ser_tx_data     <= tx_active ? tx_bit : LINE_IDLE; // (R2)
      ser_tx_drive_en <= tx_active; // (R1)
    end
  end
  // our own echo comes back on half-duplex transceivers
  // the pin synchroniser lags two cycles, so the echo tail is
  // still in the pipe after the enable drops; blank it as well
  logic [1:0] echo_hold_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) echo_hold_q <= 2'h0;
    else echo_hold_q <= {echo_hold_q[0], ser_tx_drive_en}; // (R3)
  end
  wire rx_blank = ser_tx_drive_en || (|echo_hold_q);
  assign rx_bit = rx_blank ? LINE_IDLE : rx_s2_q; // (R3)
  wire rx_done_ok = rx_pkt_done && !ser_tx_drive_en; // (R3)

  // ----------------------------------------------------------------
  // remote flag
  // ----------------------------------------------------------------
  // no source check: any station may steer the flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) remote_flag_n <= LINE_IDLE;
    else if (rx_done_ok) remote_flag_n <= !rx_flag_for_us; // (R12) (R13) (R14)
  end

  // ----------------------------------------------------------------
  // flashes and cycle pulse
  // ----------------------------------------------------------------
  logic init_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) init_q <= 1'b1;
    else init_q <= 1'b0;
  end
  nsuo_shot_if mild_sh ();
  nsuo_shot_if sev_sh ();
  nsuo_shot_if cyc_sh ();
  assign mild_sh.start = no_link_new || disconnect3 || init_q; // (R8) (R10)
  assign sev_sh.start  = no_link3_new || disconnect3 || init_q; // (R9) (R10)
  assign cyc_sh.start  = cycle_start; // (R15)

  nsuo_shot_timer #(.LEN(FLASH_CYCLES), .CNT_W(TMR_W)) u_mild (
    .clk(clk), .rst_n(rst_n), .tick(1'b1), .shot(mild_sh));
  nsuo_shot_timer #(.LEN(FLASH_CYCLES), .CNT_W(TMR_W)) u_sev (
    .clk(clk), .rst_n(rst_n), .tick(1'b1), .shot(sev_sh));
  nsuo_shot_timer #(.LEN(CYC_PULSE_BITS), .CNT_W(2)) u_cyc (
    .clk(clk), .rst_n(rst_n), .tick(bit_strobe), .shot(cyc_sh));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cycle_start_pulse_n <= LINE_IDLE;
    else cycle_start_pulse_n <= !(cyc_sh.start || cyc_sh.busy); // (R15)
  end

  // ----------------------------------------------------------------
  // fault blink
  // ----------------------------------------------------------------
  wire             fault_any = fault_switch_read || fault_flash_rom || fault_memory;
  wire [TMR_W-1:0] blink_len = fault_switch_read ? TMR_W'(BLINK1_CYC - 1) : // (R11)
                               fault_flash_rom   ? TMR_W'(BLINK2_CYC - 1) :
                                                   TMR_W'(BLINK3_CYC - 1);
  logic [TMR_W-1:0] blink_cnt_q;
  logic             blink_ph_q;
  wire              blink_wrap = blink_cnt_q >= blink_len;
  always_ff @(posedge clk or negedge rst_n) begin // (R16)
    if (!rst_n) begin
      blink_cnt_q <= '0;
      blink_ph_q  <= 1'b0;
    end else if (!fault_any) begin
      blink_cnt_q <= '0;
      blink_ph_q  <= 1'b0;
    end else begin
      blink_cnt_q <= blink_wrap ? '0 : blink_cnt_q + TMR_W'(1);
      blink_ph_q  <= blink_ph_q ^ blink_wrap; // (R11)
    end
  end

  // ----------------------------------------------------------------
  // lamp decode, fault over clash over link state
  // ----------------------------------------------------------------
  wire [ADDR_W:0] span_end = {1'b0, own_station_addr} + {1'b0, own_station_span};
  wire            clash    = (commander_station_addr == own_station_addr) || // (R7)
                             ({1'b0, commander_station_addr} > {1'b0, own_station_addr} &&
                              {1'b0, commander_station_addr} < span_end);
  wire normal  = link_any && commander_linked; // (R5)
  wire mon_on  = !fault_any && !clash && link_any; // (R6)
  wire commander_present_led_on = !fault_any && !clash && normal; // (R5)
  wire mild_on = fault_any ? blink_ph_q : (!clash && mild_sh.busy);
  wire sev_on  = fault_any ? !blink_ph_q : (clash || sev_sh.busy); // (R7)

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_monitor_led_n    <= LED_OFF;
      mild_warn_led_n       <= LED_OFF;
      severe_warn_led_n     <= LED_OFF;
      commander_present_led <= LED_OFF;
    end else begin
      link_monitor_led_n    <= mon_on ? LED_ON : LED_OFF; // (R4)
      mild_warn_led_n       <= mild_on ? LED_ON : LED_OFF; // (R4)
      severe_warn_led_n     <= sev_on ? LED_ON : LED_OFF; // (R4)
      commander_present_led <= commander_present_led_on ? LED_ON : LED_OFF; // (R4)
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  tx_enable_a: assert property (@(posedge clk) disable iff (!rst_n) // (R1)
    tx_active |=> ser_tx_drive_en && ser_tx_data == $past(tx_bit))
    else $error("drive enable low during transmission");
  echo_block_a: assert property (@(posedge clk) disable iff (!rst_n) // (R3)
    ser_tx_drive_en |-> rx_bit == LINE_IDLE)
    else $error("receive line not blocked while driving");
  echo_tail_a: assert property (@(posedge clk) disable iff (!rst_n) // (R3)
    $fell(ser_tx_drive_en) |-> rx_bit == LINE_IDLE ##1 rx_bit == LINE_IDLE)
    else $error("own echo leaked after drive released");
  normal_lamps_a: assert property (@(posedge clk) disable iff (!rst_n) // (R5)
    normal && !fault_any && !clash |=> !link_monitor_led_n && !commander_present_led)
    else $error("normal lamps not lit");
  no_cmdr_a: assert property (@(posedge clk) disable iff (!rst_n) // (R6)
    link_any && !commander_linked && !fault_any && !clash
      |=> !link_monitor_led_n && commander_present_led)
    else $error("missing commander state not shown");
  clash_only_a: assert property (@(posedge clk) disable iff (!rst_n) // (R7)
    clash && !fault_any |=> !severe_warn_led_n && mild_warn_led_n && link_monitor_led_n
      && commander_present_led)
    else $error("address clash lamps wrong");
  mild_flash_a: assert property (@(posedge clk) disable iff (!rst_n) // (R8)
    no_link_new && !fault_any && !clash |=> ##1 !mild_warn_led_n)
    else $error("no-link flash missing");
  flag_set_a: assert property (@(posedge clk) disable iff (!rst_n) // (R12)
    rx_pkt_done && rx_flag_for_us && !ser_tx_drive_en |=> !remote_flag_n)
    else $error("flag not driven low");
  flag_clr_a: assert property (@(posedge clk) disable iff (!rst_n) // (R13)
    rx_pkt_done && !rx_flag_for_us && !ser_tx_drive_en |=> remote_flag_n)
    else $error("flag not released");
  cycle_pulse_a: assert property (@(posedge clk) disable iff (!rst_n) // (R15)
    cycle_start && !bit_strobe ##1 !bit_strobe |=> !cycle_start_pulse_n)
    else $error("cycle pulse missing");
endmodule // nsuo_status_out

// ==== nsuo_pkg.sv ====
// shared constants for the network status and utility outputs
package nsuo_pkg;
  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ         = 20_000_000;
  localparam int unsigned LINE_MAX_BPS   = 12_000_000;
  localparam int unsigned FLASH_MS       = 50;
  localparam int unsigned FLASH_CYC      = CLK_HZ / 1000 * FLASH_MS;
  localparam int unsigned BLINK_SW_S     = 1;
  localparam int unsigned BLINK_ROM_S    = 2;
  localparam int unsigned BLINK_MEM_S    = 3;
  localparam int unsigned BLINK_SW_CYC   = CLK_HZ * BLINK_SW_S;
  localparam int unsigned BLINK_ROM_CYC  = CLK_HZ * BLINK_ROM_S;
  localparam int unsigned BLINK_MEM_CYC  = CLK_HZ * BLINK_MEM_S;
  localparam int unsigned CYC_PULSE_BITS = 2;
  // ----------------------------------------------------------------
  // widths and reset levels
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W         = 6;
  localparam int unsigned TMR_W          = 26;
  localparam logic        LED_OFF        = 1'b1;
  localparam logic        LED_ON         = 1'b0;
  localparam logic        LINE_IDLE      = 1'b1;
  typedef logic [ADDR_W-1:0] nsuo_addr_t;
endpackage

// ==== nsuo_shot_if.sv ====
// start and busy pair between the top and a one-shot timer
`timescale 1ns/1ps
interface nsuo_shot_if;
  logic start;
  logic busy;
  modport ctl (output start, input busy);
  modport tmr (input start, output busy);
endinterface

// ==== nsuo_shot_timer.sv ====
// retriggerable one-shot timer counting ticks
`timescale 1ns/1ps
module nsuo_shot_timer #(
  parameter int unsigned LEN   = 2,
  parameter int unsigned CNT_W = 26
) (
  input  wire logic  clk,
  input  wire logic  rst_n,
  input  wire logic  tick,
  nsuo_shot_if.tmr   shot
);
  import nsuo_pkg::*;

  logic             busy_q;
  logic [CNT_W-1:0] cnt_q;
  wire              last = tick && (cnt_q == CNT_W'(LEN - 1));

  // ----------------------------------------------------------------
  // counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin // (R16)
    if (!rst_n) begin
      busy_q <= 1'b0;
      cnt_q  <= '0;
    end else if (shot.start) begin
      busy_q <= 1'b1;
      cnt_q  <= '0;
    end else if (busy_q && tick) begin
      busy_q <= !last;
      cnt_q  <= cnt_q + CNT_W'(1);
    end
  end

  assign shot.busy = busy_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  shot_start_a: assert property (@(posedge clk) disable iff (!rst_n) // (R16)
    shot.start |=> busy_q && cnt_q == '0)
    else $error("one-shot did not start");
  shot_end_a: assert property (@(posedge clk) disable iff (!rst_n) // (R16)
    busy_q && last && !shot.start |=> !busy_q)
    else $error("one-shot did not end after its length");
endmodule // nsuo_shot_timer

// ==== nsuo_xcvr_model.sv ====
// transceiver stand-in for the serial link, with half-duplex echo
`timescale 1ns/1ps
module nsuo_xcvr_model (
  input  wire logic tx_data,
  input  wire logic drive_en,
  input  wire logic net_bit,
  output logic      rx_data
);
  // ----------------------------------------------------------------
  // line
  // ----------------------------------------------------------------
  // worst case: own driver output loops straight back while enabled
  assign rx_data = drive_en ? tx_data : net_bit;
endmodule // nsuo_xcvr_model

// ==== net_status_utility_outputs_tb_top.sv ====
// self-checking bench for the status and utility outputs
`timescale 1ns/1ps
module net_status_utility_outputs_tb_top;
  import nsuo_pkg::*;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  localparam int unsigned FL = 20;
  logic       clk, rstn, bit_strobe, tx_active, tx_bit, net_bit, rx_line;
  logic       link_any, commander_linked, no_link_new, no_link3_new, disconnect3;
  logic       f_sw, f_rom, f_mem, rx_pkt_done, rx_flag_for_us, cycle_start;
  logic       ser_tx_data, ser_tx_drive_en, rx_bit, link_n, mild_n, sev_n, cmdr_n, flag_n, cyc_n;
  nsuo_addr_t own_a, span_a, cmd_a;
  int         failures, compares;
  // short counts keep flashes and blinks within a brief run
  nsuo_status_out #(.FLASH_CYCLES(FL), .BLINK1_CYC(40), .BLINK2_CYC(60), .BLINK3_CYC(80)) i_nsuo_status_out (
    .clk(clk), .rstn(rstn), .bit_strobe(bit_strobe), .tx_active(tx_active), .tx_bit(tx_bit),
    .ser_tx_data(ser_tx_data), .ser_tx_drive_en(ser_tx_drive_en), .ser_rx_data(rx_line), .rx_bit(rx_bit),
    .own_station_addr(own_a), .own_station_span(span_a), .commander_station_addr(cmd_a),
    .link_any(link_any), .commander_linked(commander_linked), .no_link_new(no_link_new),
    .no_link3_new(no_link3_new), .disconnect3(disconnect3), .fault_switch_read(f_sw),
    .fault_flash_rom(f_rom), .fault_memory(f_mem), .rx_pkt_done(rx_pkt_done),
    .rx_flag_for_us(rx_flag_for_us), .cycle_start(cycle_start), .link_monitor_led_n(link_n),
    .mild_warn_led_n(mild_n), .severe_warn_led_n(sev_n), .commander_present_led(cmdr_n),
    .remote_flag_n(flag_n), .cycle_start_pulse_n(cyc_n));
  nsuo_xcvr_model i_nsuo_xcvr_model (
    .tx_data(ser_tx_data), .drive_en(ser_tx_drive_en), .net_bit(net_bit), .rx_data(rx_line));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input string nm, input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %b seen %b", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
  endtask
  task automatic end_of_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("drive enable in reset", ser_tx_drive_en, 1'b0);
    chk("flag in reset", flag_n, 1'b1);
    chk("cycle pulse in reset", cyc_n, 1'b1);
    rstn = 1'b1;
    cyc(7);
    chk("mild reset flash", mild_n, LED_ON);
    chk("severe reset flash", sev_n, LED_ON);
    cyc(FL + 10);
    chk("flash over", mild_n & sev_n, LED_OFF);
    chk("monitor without link", link_n, LED_OFF);
    $display("test reset done");
  endtask
  task automatic t_tx();
    tx_active = 1'b1;
    bit_strobe = 1'b1;
    rx_flag_for_us = 1'b1;
    for (int i = 0; i < 4; i++) begin
      tx_bit = i[0];
      rx_pkt_done = (i == 2);
      cyc(1);
      chk("drive enable", ser_tx_drive_en, 1'b1);
      chk("tx data", ser_tx_data, i[0]);
      chk("echo blocked", rx_bit, 1'b1);
    end
    {tx_active, bit_strobe, rx_pkt_done} = 3'b000;
    cyc(1);
    chk("drive released", ser_tx_drive_en, 1'b0);
    chk("tx idle", ser_tx_data, LINE_IDLE);
    chk("echo tail blocked", rx_bit, 1'b1);
    chk("own packet ignored", flag_n, 1'b1);
    net_bit = 1'b0;
    cyc(4);
    chk("rx passes", rx_bit, 1'b0);
    net_bit = 1'b1;
    $display("test tx done");
  endtask
  task automatic t_flag();
    // back to back packets, flag set and cleared alternately
    for (int i = 0; i < 5; i++) begin
      rx_pkt_done = 1'b1;
      rx_flag_for_us = ~i[0];
      cyc(1);
      chk("remote flag", flag_n, i[0]);
    end
    rx_pkt_done = 1'b0;
    cyc(3);
    chk("flag holds", flag_n, 1'b0);
    $display("test flag done");
  endtask
  task automatic t_cyc();
    pulse(cycle_start);
    chk("cycle pulse low", cyc_n, 1'b0);
    cyc(1);
    pulse(bit_strobe);
    cyc(2);
    chk("after one bit", cyc_n, 1'b0);
    pulse(bit_strobe);
    cyc(2);
    chk("after two bits", cyc_n, 1'b1);
    $display("test cycle done");
  endtask
  task automatic t_lamps();
    logic [1:0] lk [3] = '{2'b11, 2'b10, 2'b00};
    logic [1:0] ex [3] = '{2'b00, 2'b01, 2'b11};
    for (int i = 0; i < 3; i++) begin
      {link_any, commander_linked} = lk[i];
      cyc(2);
      chk("monitor lamp", link_n, ex[i][1]);
      chk("commander lamp", cmdr_n, ex[i][0]);
    end
    {link_any, commander_linked} = 2'b11;
    for (int i = 0; i < 2; i++) begin
      span_a = 6'h01 + 6'(2 * i);
      cmd_a = own_a + 6'(2 * i);
      cyc(2);
      chk("clash severe", sev_n, LED_ON);
      chk("clash others", mild_n & link_n & cmdr_n, LED_OFF);
    end
    {span_a, cmd_a} = {6'h01, 6'h05};
    cyc(2);
    $display("test lamps done");
  endtask
  task automatic flash(ref logic ev, input logic em, input logic es);
    pulse(ev);
    cyc(2);
    chk("mild flash", mild_n, em);
    chk("severe flash", sev_n, es);
    cyc(FL + 8);
    chk("flash ended", mild_n & sev_n, LED_OFF);
    $display("test flash done");
  endtask
  task automatic t_fault();
    logic a;
    int   p [3] = '{40, 60, 80};
    for (int i = 0; i < 3; i++) begin
      {f_sw, f_rom, f_mem} = 3'b100 >> i;
      cyc(p[i] / 2);
      a = mild_n;
      chk("blink opposite", sev_n, ~a);
      chk("monitor off", link_n, LED_OFF);
      cyc(p[i]);
      chk("blink toggles", mild_n, ~a);
      {f_sw, f_rom, f_mem} = 3'b000;
      cyc(4);
    end
    $display("test fault done");
  endtask
  // ----------------------------------------------------------------
  // sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    {rstn, bit_strobe, tx_active, tx_bit, net_bit} = 5'b00001;
    {link_any, commander_linked, no_link_new, no_link3_new, disconnect3} = '0;
    {f_sw, f_rom, f_mem, rx_pkt_done, rx_flag_for_us, cycle_start} = '0;
    {own_a, span_a, cmd_a} = {6'h01, 6'h01, 6'h05};
    {failures, compares} = '0;
    cyc(3);
    t_reset();
    t_tx();
    t_flag();
    t_cyc();
    t_lamps();
    flash(no_link_new, LED_ON, LED_OFF);
    flash(no_link3_new, LED_OFF, LED_ON);
    flash(disconnect3, LED_ON, LED_ON);
    t_fault();
    end_of_test();
  end
  // the whole sequence takes well under 1000 cycles
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    end_of_test();
  end
endmodule // net_status_utility_outputs_tb_top
